// ### logic/sps_defs.svh
// Register offsets, field positions, reset values and timing counts of the supervisor
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH
`define SPS_OFF_DIV_DEN       8'h00
`define SPS_OFF_OT_SETUP      8'h04
`define SPS_OFF_OT_SEQ        8'h08
`define SPS_OFF_SOFF_SEQ      8'h0C
`define SPS_OFF_PWR_SEQ       8'h10
`define SPS_OFF_TRIP_SEL      8'h14
`define SPS_OFF_DET_TIME      8'h18
`define SPS_OFF_ALM_SEQ       8'h1C
`define SPS_OFF_ESTOP_TRQ     8'h20
`define SPS_OFF_OVL_LVL       8'h24
`define SPS_OFF_OVS_LVL       8'h28
`define SPS_OFF_IRQ_STAT      8'h2C
`define SPS_OFF_IRQ_MASK      8'h30
`define SPS_OFF_STATE         8'h34
`define SPS_DIV_DEN_MAX       32'h0080_0000
`define SPS_OT_SEL_MAX        16'h0002
`define SPS_SEQ9_MAX          16'h0009
`define SPS_ALM_SEQ_MAX       16'h0007
`define SPS_DET_MIN           16'h0014
`define SPS_DET_MAX           16'h07D0
`define SPS_TRQ_MAX           16'h01F4
`define SPS_OVL_DEFAULT       16'h0073
`define SPS_OVS_MAX           16'h4E20
`define SPS_TRIP_BIT          0
`define SPS_ALWAYS_BIT        1
`define SPS_IRQ_PWR_BIT       0
`define SPS_IRQ_TRIP_BIT      1
`define SPS_IRQ_OVS_BIT       2
`define SPS_IRQ_OVL_BIT       3
`define SPS_RST_DET_TIME      16'h0046
`define SPS_RST_OT_SETUP      16'h0001
`define SPS_RST_ZERO          16'h0000
`define SPS_CLK_HZ            50000000
`define SPS_TICK_MS           1
`define SPS_TICK_CYCLES       ((`SPS_CLK_HZ / 1000) * `SPS_TICK_MS)
`endif

// ### logic/sps_pkg.sv
// Types shared by the servo protection supervisor files
package sps_pkg;
  // Monitored inputs from the power stage and feedback
  typedef struct packed {
    logic        main_power_ok;
    logic        servo_on;
    logic        estop;
    logic [15:0] motor_speed;
    logic [15:0] motor_load;
  } sps_mon_t;
  // Motor ratings used for clamping
  typedef struct packed {
    logic [15:0] motor_ovs_level;
    logic [15:0] normal_torque;
  } sps_motor_t;
  // Protection results
  typedef struct packed {
    logic        servo_off_req;
    logic        uv_trip;
    logic        overspeed_error;
    logic        overload;
    logic [15:0] torque_limit;
  } sps_prot_t;
  typedef enum logic [2:0] {
    SPS_WAIT = 3'b001,
    SPS_RESP = 3'b010,
    SPS_IDLE = 3'b100
  } sps_bus_t;
endpackage : sps_pkg

// ### logic/sps_power_timer.sv
// Main power interruption timer
`timescale 1ns/100ps
`default_nettype none
module sps_power_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Timing
  input  wire logic        tick,
  input  wire logic        enable,
  input  wire logic        power_ok,
  input  wire logic [15:0] limit,
  // Result level
  output logic             expired
);
  logic [15:0] ms_count; // Milliseconds without power
  // Count while interrupted, restart on restore
  always_ff @(posedge aclk) begin
    if (!aresetn || power_ok || !enable) begin
      ms_count <= 16'h0000;
      expired  <= 1'b0;
    end else if (tick && !expired) begin
      ms_count <= ms_count + 16'h0001;
      // Strictly longer than the set time
      if (ms_count >= limit) expired <= 1'b1;
    end
  end
endmodule // sps_power_timer
`default_nettype wire

// ### logic/sps_tick.sv
// Divider making the 1 ms enable pulse
`timescale 1ns/100ps
`default_nettype none
module sps_tick #(
  parameter int CYCLES = 50000
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // One-cycle enable
  output logic      tick
);
  // A divide by one would never drop the pulse
  if (CYCLES < 2) begin : g_bad_cycles
    $error("sps_tick: CYCLES too small");
  end
  logic [31:0] count; // Cycles since last tick
  // Free running divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count == 32'(CYCLES - 1)) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule // sps_tick
`default_nettype wire

// ### logic/sps_top.sv
// Servo protection supervisor with AXI4-Lite register slave
//
// Notes on behaviour
// - Division denominator accepted from 0 to 8388608
// - Over-travel inhibit setup selector 0 to 2
// - Over-travel stop sequence selector 0 to 2
// - Servo-off sequence selector 0 to 9
// - Main power off sequence selector 0 to 9
// - Trip bit0 chooses servo-off or undervoltage trip
// - Alarm only after interruption exceeds detect time
// - Detect time in ms, 20 to 2000
// - Setting 2000 disables power off detection
// - Alarm stop sequence selector 0 to 7
// - Emergency stop limits torque, 0 to 500
// - Zero emergency torque uses normal limit
// - Zero overload setting means 115 percent
// - Overload level clamped to 115 percent
// - Overspeed error above configured r/min level
// - Zero overspeed setting uses motor level
// - Overspeed threshold clamped to motor level
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sps_defs.svh"
module sps_top #(
  parameter int TICK_CYCLES = `SPS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Monitored conditions, same clock domain
  input  wire sps_pkg::sps_mon_t    mon,
  input  wire sps_pkg::sps_motor_t  motor,
  // Protection results
  output sps_pkg::sps_prot_t        prot,
  output logic                      irq
);
  import sps_pkg::*;

  // Refuse a tick divider that cannot make a one-cycle pulse
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("sps_top: TICK_CYCLES too small");
  end

  // Parameter registers
  logic [31:0] pulse_output_div_denominator;
  logic [15:0] overtravel_inhibit_setup;
  logic [15:0] overtravel_stop_sequence;
  logic [15:0] servo_off_sequence;
  logic [15:0] main_power_off_sequence;
  logic [15:0] power_loss_trip_select;
  logic [15:0] power_loss_detect_time;
  logic [15:0] alarm_stop_sequence;
  logic [15:0] emergency_torque_limit;
  logic [15:0] overload_level;
  logic [15:0] overspeed_level;
  logic [3:0]  irq_status;      // Sticky events
  logic [3:0]  irq_mask;        // One enables an event

  // Bus handshake state
  logic        aw_held;         // Write address taken
  logic        w_held;          // Write data taken
  logic [7:0]  aw_addr;         // Held write address
  logic [31:0] w_data;          // Held write data
  logic [3:0]  w_strb;          // Held strobes
  logic        wr_fire;         // Both halves present
  logic        wr_hit;          // Address decoded
  logic [31:0] rd_word;         // Read mux
  logic        rd_hit;          // Read address decoded
  logic [31:0] merged;          // Strobe-merged write value
  logic        tick;            // 1 ms enable
  logic        alarm_level;     // Timer expired
  logic        detect_enable;   // Detection armed
  logic [15:0] ovl_eff;         // Effective overload level
  logic [15:0] ovs_eff;         // Effective overspeed level
  logic        alarm_prev;      // For edge detection
  logic [3:0]  event_now;       // Alarm edge pulses and result levels

  sps_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  // Disabled at 2000, else armed when servo on or always-detect set
  assign detect_enable = (power_loss_detect_time != `SPS_DET_MAX) &&
                         (power_loss_trip_select[`SPS_ALWAYS_BIT] || mon.servo_on);

  sps_power_timer u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick     (tick),
    .enable   (detect_enable),
    .power_ok (mon.main_power_ok),
    .limit    (power_loss_detect_time),
    .expired  (alarm_level)
  );

  // Write fires once both halves are held
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Merge byte strobes into the old register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Read mux; an unmapped address gives zero data and a refusal
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `SPS_OFF_DIV_DEN:   rd_word = pulse_output_div_denominator;
      `SPS_OFF_OT_SETUP:  rd_word = {16'h0000, overtravel_inhibit_setup};
      `SPS_OFF_OT_SEQ:    rd_word = {16'h0000, overtravel_stop_sequence};
      `SPS_OFF_SOFF_SEQ:  rd_word = {16'h0000, servo_off_sequence};
      `SPS_OFF_PWR_SEQ:   rd_word = {16'h0000, main_power_off_sequence};
      `SPS_OFF_TRIP_SEL:  rd_word = {16'h0000, power_loss_trip_select};
      `SPS_OFF_DET_TIME:  rd_word = {16'h0000, power_loss_detect_time};
      `SPS_OFF_ALM_SEQ:   rd_word = {16'h0000, alarm_stop_sequence};
      `SPS_OFF_ESTOP_TRQ: rd_word = {16'h0000, emergency_torque_limit};
      `SPS_OFF_OVL_LVL:   rd_word = {16'h0000, overload_level};
      `SPS_OFF_OVS_LVL:   rd_word = {16'h0000, overspeed_level};
      `SPS_OFF_IRQ_STAT:  rd_word = {28'h000_0000, irq_status};
      `SPS_OFF_IRQ_MASK:  rd_word = {28'h000_0000, irq_mask};
      `SPS_OFF_STATE:     rd_word = {26'h000_0000, alarm_level, prot.uv_trip,
                                     prot.servo_off_req, prot.overspeed_error,
                                     prot.overload, detect_enable};
      default:            rd_hit  = 1'b0;
    endcase
  end

  // Write address decode
  always_comb begin
    wr_hit = (aw_addr <= `SPS_OFF_STATE) && (aw_addr[1:0] == 2'b00) &&
             (aw_addr != `SPS_OFF_STATE);
    merged = 32'h0000_0000;
    case (aw_addr)
      `SPS_OFF_DIV_DEN: merged = merge(pulse_output_div_denominator, w_data, w_strb);
      default:          merged = merge(32'h0000_0000, w_data, w_strb);
    endcase
  end

  // Write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // Write response; out-of-range values are refused with SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_hit && in_range(aw_addr, merged)) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Range check per register
  function automatic logic in_range(input logic [7:0] a, input logic [31:0] v);
    logic ok;
    ok = (v[31:16] == 16'h0000);
    case (a)
      `SPS_OFF_DIV_DEN:   ok = (v <= `SPS_DIV_DEN_MAX);
      `SPS_OFF_OT_SETUP,
      `SPS_OFF_OT_SEQ:    ok = ok && (v[15:0] <= `SPS_OT_SEL_MAX);
      `SPS_OFF_SOFF_SEQ,
      `SPS_OFF_PWR_SEQ:   ok = ok && (v[15:0] <= `SPS_SEQ9_MAX);
      `SPS_OFF_TRIP_SEL:  ok = ok && (v[15:0] <= 16'h0003);
      `SPS_OFF_DET_TIME:  ok = ok && (v[15:0] >= `SPS_DET_MIN) && (v[15:0] <= `SPS_DET_MAX);
      `SPS_OFF_ALM_SEQ:   ok = ok && (v[15:0] <= `SPS_ALM_SEQ_MAX);
      `SPS_OFF_ESTOP_TRQ,
      `SPS_OFF_OVL_LVL:   ok = ok && (v[15:0] <= `SPS_TRQ_MAX);
      `SPS_OFF_OVS_LVL:   ok = ok && (v[15:0] <= `SPS_OVS_MAX);
      default:            ok = 1'b1;
    endcase
    return ok;
  endfunction

  // Parameter storage; a refused value leaves the old one in place
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_output_div_denominator <= 32'h0000_0000;
      overtravel_inhibit_setup     <= `SPS_RST_OT_SETUP;
      overtravel_stop_sequence     <= `SPS_RST_ZERO;
      servo_off_sequence           <= `SPS_RST_ZERO;
      main_power_off_sequence      <= `SPS_RST_ZERO;
      power_loss_trip_select       <= `SPS_RST_ZERO;
      power_loss_detect_time       <= `SPS_RST_DET_TIME;
      alarm_stop_sequence          <= `SPS_RST_ZERO;
      emergency_torque_limit       <= `SPS_RST_ZERO;
      overload_level               <= `SPS_RST_ZERO;
      overspeed_level              <= `SPS_RST_ZERO;
      irq_mask                     <= 4'h0;
    end else if (wr_fire && wr_hit && in_range(aw_addr, merged)) begin
      case (aw_addr)
        `SPS_OFF_DIV_DEN:   pulse_output_div_denominator <= merged;
        `SPS_OFF_OT_SETUP:  overtravel_inhibit_setup     <= merged[15:0];
        `SPS_OFF_OT_SEQ:    overtravel_stop_sequence     <= merged[15:0];
        `SPS_OFF_SOFF_SEQ:  servo_off_sequence           <= merged[15:0];
        `SPS_OFF_PWR_SEQ:   main_power_off_sequence      <= merged[15:0];
        `SPS_OFF_TRIP_SEL:  power_loss_trip_select       <= merged[15:0];
        `SPS_OFF_DET_TIME:  power_loss_detect_time       <= merged[15:0];
        `SPS_OFF_ALM_SEQ:   alarm_stop_sequence          <= merged[15:0];
        `SPS_OFF_ESTOP_TRQ: emergency_torque_limit       <= merged[15:0];
        `SPS_OFF_OVL_LVL:   overload_level               <= merged[15:0];
        `SPS_OFF_OVS_LVL:   overspeed_level              <= merged[15:0];
        `SPS_OFF_IRQ_MASK:  irq_mask                     <= merged[3:0];
        default: ;
      endcase
    end
  end

  // Read channel; one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Effective thresholds with zero defaults and clamps
  always_comb begin
    ovl_eff = (overload_level == 16'h0000) ? `SPS_OVL_DEFAULT : overload_level;
    if (ovl_eff > `SPS_OVL_DEFAULT) ovl_eff = `SPS_OVL_DEFAULT;
    ovs_eff = (overspeed_level == 16'h0000) ? motor.motor_ovs_level : overspeed_level;
    if (ovs_eff > motor.motor_ovs_level) ovs_eff = motor.motor_ovs_level;
  end

  // Protection outputs, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot <= '0;
    end else begin
      prot.overspeed_error <= (mon.motor_speed > ovs_eff);
      prot.overload        <= (mon.motor_load > ovl_eff);
      // Trip or servo-off chosen by bit0; the trip latches until reset
      prot.uv_trip       <= prot.uv_trip ||
                            (alarm_level && power_loss_trip_select[`SPS_TRIP_BIT]);
      prot.servo_off_req <= alarm_level && !power_loss_trip_select[`SPS_TRIP_BIT];
      if (mon.estop && emergency_torque_limit != 16'h0000)
        prot.torque_limit <= emergency_torque_limit;
      else
        prot.torque_limit <= motor.normal_torque;
    end
  end

  // Events: power and trip pulse on the alarm rising edge; overspeed and overload pass as levels
  always_comb begin
    event_now = 4'h0;
    event_now[`SPS_IRQ_PWR_BIT]  = alarm_level && !alarm_prev;
    event_now[`SPS_IRQ_TRIP_BIT] = alarm_level && !alarm_prev &&
                                   power_loss_trip_select[`SPS_TRIP_BIT];
    event_now[`SPS_IRQ_OVS_BIT]  = prot.overspeed_error;
    event_now[`SPS_IRQ_OVL_BIT]  = prot.overload;
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 4'h0;
      alarm_prev <= 1'b0;
      irq        <= 1'b0;
    end else begin
      alarm_prev <= alarm_level;
      if (wr_fire && aw_addr == `SPS_OFF_IRQ_STAT)
        irq_status <= (irq_status & ~merged[3:0]) | event_now;
      else
        irq_status <= irq_status | event_now;
      irq <= |(irq_status & irq_mask);
    end
  end

  // Overspeed follows the speed against the effective level
  ovs_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mon.motor_speed > ovs_eff) |=> prot.overspeed_error) else $error("overspeed missed");
  // Threshold never above motor level
  ovs_clamp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ovs_eff <= motor.motor_ovs_level) else $error("overspeed clamp broken");
  // Overload never above the default
  ovl_clamp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ovl_eff <= `SPS_OVL_DEFAULT && ovl_eff != 16'h0000) else $error("overload clamp");
  // Detection off at 2000
  det_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (power_loss_detect_time == `SPS_DET_MAX) |-> ##2 !alarm_level) else $error("detect on");
  // Power restored clears the alarm
  pwr_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mon.main_power_ok |=> !alarm_level) else $error("alarm stuck");
  // Trip selection routes the alarm
  trip_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (alarm_level && power_loss_trip_select[0]) |=> prot.uv_trip) else $error("no trip");
  // Servo-on gating without always-detect
  servo_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!mon.servo_on && !power_loss_trip_select[1]) |=> !alarm_level) else $error("gating");
  // Emergency torque applied when set
  estop_trq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mon.estop && emergency_torque_limit != 16'h0000) |=>
      prot.torque_limit == $past(emergency_torque_limit)) else $error("estop torque");
  // Detect time stays within range
  det_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    power_loss_detect_time >= `SPS_DET_MIN && power_loss_detect_time <= `SPS_DET_MAX)
    else $error("detect time range");
endmodule // sps_top
`default_nettype wire

// ### tb/sps_plant.sv
// Behavioural power stage and motor feedback facing the supervisor
`timescale 1ns/100ps
`default_nettype none
module sps_plant
  import sps_pkg::*;
(
  // Commands from the bench
  input  wire logic                power_cut,
  input  wire logic                run,
  input  wire logic                stop_req,
  input  wire logic [15:0]         speed,
  input  wire logic [15:0]         load,
  // Toward the supervisor
  output wire sps_pkg::sps_mon_t   mon,
  output wire sps_pkg::sps_motor_t motor
);
  // Ratings of one motor; kept low so the clamps can bite
  localparam logic [15:0] MOTOR_OVS = 16'h0BB8;
  localparam logic [15:0] NORM_TRQ  = 16'h012C;
  // Supply and feedback follow the bench with no filtering
  assign mon = '{main_power_ok: !power_cut, servo_on: run, estop: stop_req,
                 motor_speed: speed, motor_load: load};
  assign motor = '{motor_ovs_level: MOTOR_OVS, normal_torque: NORM_TRQ};
endmodule // sps_plant
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the servo protection supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sps_pkg::*;
  // Clock, reset and register bus
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, cut, run, stop;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v, last;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] speed, load;
  sps_mon_t    mon;
  sps_motor_t  motor;
  sps_prot_t   prot;
  int          n_mismatch, checks;
  // Ordinary writes: address, data, accepted
  logic [40:0] rows [25] = '{
    {8'h00,32'h0080_0000,1'b1}, {8'h00,32'h0080_0001,1'b0}, {8'h04,32'h2,1'b1},
    {8'h04,32'h3,1'b0}, {8'h04,32'h1_0001,1'b0}, {8'h08,32'h2,1'b1}, {8'h08,32'h3,1'b0},
    {8'h0C,32'h9,1'b1}, {8'h0C,32'hA,1'b0}, {8'h10,32'h9,1'b1}, {8'h10,32'hA,1'b0},
    {8'h1C,32'h7,1'b1}, {8'h1C,32'h8,1'b0}, {8'h18,32'h14,1'b1}, {8'h18,32'h13,1'b0},
    {8'h18,32'h7D0,1'b1}, {8'h18,32'h7D1,1'b0}, {8'h20,32'h1F4,1'b1}, {8'h20,32'h1F5,1'b0},
    {8'h28,32'h4E20,1'b1}, {8'h28,32'h4E21,1'b0}, {8'h14,32'h3,1'b1}, {8'h14,32'h4,1'b0},
    {8'h24,32'h1F4,1'b1}, {8'h24,32'h1F5,1'b0}};

  sps_top #(.TICK_CYCLES(10)) sps_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mon(mon), .motor(motor), .prot(prot), .irq(irq));
  sps_plant sps_plant_i (.power_cut(cut), .run(run), .stop_req(stop), .speed(speed),
    .load(load), .mon(mon), .motor(motor));

  // Free-running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Comparison, counted either way
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write; address and data drop as each is taken, wait ends on bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // Read; data taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata; rs = rresp;
    rready <= 1'b0;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    wt(30000);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cut, run, stop} = '0;
    {awaddr, araddr, wdata, speed, load} = '0;
    wstrb = 4'hF;
    wt(3);
    aresetn <= 1'b1;
    rd(8'h04, v, r); chk(v, 32'h1);
    rd(8'h18, v, r); chk(v, 32'h46);
    // Torque limit follows the normal rating as soon as reset is released
    chk({prot, irq}, {11'h000, 4'h0, 16'h012C, 1'b0});
    // Table: accepted values read back, refused ones leave the old value
    last = '0;
    for (int i = 0; i < 25; i++) begin
      wr(rows[i][40:33], rows[i][32:1], r);
      chk({30'h0, r}, rows[i][0] ? 32'h0 : 32'h2);
      if (rows[i][0]) last = rows[i][32:1];
      rd(rows[i][40:33], v, r);
      chk(v, last);
      chk({30'h0, r}, 32'h0);
    end
    // Unmapped and read-only places
    wr(8'h3C, 32'h1, r); chk({30'h0, r}, 32'h2);
    rd(8'h3C, v, r); chk(v, 32'h0); chk({30'h0, r}, 32'h2);
    wr(8'h34, 32'h1, r); chk({30'h0, r}, 32'h2);
    // Emergency stop torque and its zero fallback
    stop <= 1'b1;
    wr(8'h20, 32'h0, r); wt(3); chk(prot.torque_limit, 16'h012C);
    wr(8'h20, 32'hC8, r); wt(3); chk(prot.torque_limit, 16'h00C8);
    // Overload default and clamp
    wr(8'h24, 32'h0, r); load <= 16'h0073; wt(3); chk(prot.overload, 1'b0);
    load <= 16'h0074; wt(3); chk(prot.overload, 1'b1);
    wr(8'h24, 32'h1F4, r); wt(3); chk(prot.overload, 1'b1);
    // Overspeed: motor fallback, own level, clamp
    wr(8'h28, 32'h0, r); speed <= 16'h0BB9; wt(3); chk(prot.overspeed_error, 1'b1);
    speed <= 16'h0BB8; wt(3); chk(prot.overspeed_error, 1'b0);
    wr(8'h28, 32'h3E8, r); speed <= 16'h03E9; wt(3); chk(prot.overspeed_error, 1'b1);
    speed <= 16'h03E8; wt(3); chk(prot.overspeed_error, 1'b0);
    wr(8'h28, 32'h4E20, r); speed <= 16'h0BB9; wt(3); chk(prot.overspeed_error, 1'b1);
    // Sticky status, mask bit of one enables, write-one-to-clear, set wins over clear
    speed <= 16'h0; load <= 16'h0; stop <= 1'b0;
    wr(8'h2C, 32'hF, r); wr(8'h30, 32'h4, r); wt(2); chk(irq, 1'b0);
    speed <= 16'h0BB9; wt(3); wr(8'h2C, 32'h4, r); rd(8'h2C, v, r); chk(v, 32'h4);
    speed <= 16'h0; wt(3); chk(irq, 1'b1);
    wr(8'h30, 32'h0, r); wt(2); chk(irq, 1'b0);
    wr(8'h2C, 32'h4, r); rd(8'h2C, v, r); chk(v, 32'h0);
    // Power loss timing, always armed, servo off action: 20 ticks of 10 cycles
    wr(8'h18, 32'h14, r); wr(8'h14, 32'h2, r);
    cut <= 1'b1; wt(150); rd(8'h2C, v, r); chk(v, 32'h0);
    wt(100); rd(8'h2C, v, r); chk(v & 32'h1, 32'h1);
    chk({prot.servo_off_req, prot.uv_trip}, 2'b10);
    cut <= 1'b0; wt(3); wr(8'h2C, 32'hF, r);
    // Short gaps restart the count
    cut <= 1'b1; wt(120); cut <= 1'b0; wt(2); cut <= 1'b1; wt(120);
    rd(8'h2C, v, r); chk(v, 32'h0);
    // Servo-on-only detection ignores loss while servo is off
    cut <= 1'b0; wr(8'h14, 32'h0, r); cut <= 1'b1; wt(300);
    rd(8'h2C, v, r); chk(v, 32'h0);
    // Setting 2000 disables detection
    cut <= 1'b0; wr(8'h18, 32'h7D0, r); wr(8'h14, 32'h2, r); cut <= 1'b1; wt(300);
    rd(8'h2C, v, r); chk(v, 32'h0);
    // Trip choice latches the undervoltage trip
    cut <= 1'b0; wr(8'h18, 32'h14, r); wr(8'h14, 32'h1, r); run <= 1'b1; cut <= 1'b1; wt(300);
    chk(prot.uv_trip, 1'b1);
    // Reset in mid-run drops the latched trip and restores the defaults
    aresetn <= 1'b0; wt(3); aresetn <= 1'b1;
    rd(8'h18, v, r); chk(v, 32'h46);
    chk(prot.uv_trip, 1'b0);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
